/* File: include/gpdm_pkg.sv */
// package for the two-port gpio block with drive modes
// assumes an 8-bit processor i/o space with byte-wide register access
package gpdm_pkg;
   localparam logic [7:0] OFS_PORT0_DATA    = 8'h00;
   localparam logic [7:0] OFS_PORT1_DATA    = 8'h01;
   localparam logic [7:0] OFS_AUX_INPUT     = 8'h02;
   localparam logic [7:0] OFS_PORT0_SEL_LO  = 8'h0A;
   localparam logic [7:0] OFS_PORT0_SEL_HI  = 8'h0B;
   localparam logic [7:0] OFS_PORT1_SEL_LO  = 8'h0C;
   localparam logic [7:0] OFS_PORT1_SEL_HI  = 8'h0D;
   localparam logic [7:0] RESET_BYTE        = 8'h00;
   localparam int         AUX_DPLUS_BIT     = 5;
   localparam int         AUX_DMINUS_BIT    = 4;
   localparam int         AUX_CRYSTAL_BIT   = 1;
   localparam int         AUX_REGULATOR_BIT = 0;
   localparam int         PORT_WIDTH        = 8;
   localparam int         PORT1_NARROW      = 2;

   // per-pin drive decode: one-hot transistor enables and strength
   typedef enum logic [2:0]
   {
      GPDM_HIZ     = 3'b000,
      GPDM_SINK2   = 3'b001,
      GPDM_SINK8   = 3'b010,
      GPDM_SINK50  = 3'b011,
      GPDM_DRIVEHI = 3'b100,
      GPDM_RESIST  = 3'b101
   } gpdm_drive_t;
endpackage : gpdm_pkg

/* File: verilog/gpdm_pin_drive.sv */
// one pin's driver selection from its data bit and two drive-select bits
// assumes the pad turns the enables into transistor gates
`timescale 1ns/1ps
module gpdm_pin_drive
   import gpdm_pkg::*;
(
   input  wire logic dataBit,
   input  wire logic selLo,
   input  wire logic selHi,
   output logic      sinkOn,
   output logic      sourceOn,
   output logic      pullupOn,
   output logic [1:0] sinkStrength,
   output logic      ttlThreshold
);
   gpdm_drive_t mode;

   always_comb
   begin
      mode = GPDM_HIZ;
      if (selLo && dataBit)
         mode = GPDM_DRIVEHI;
      else if (selHi && !selLo && dataBit)
         mode = GPDM_RESIST;
      else if (selHi && !selLo && !dataBit)
         mode = GPDM_SINK2;
      else if (!selHi && selLo && !dataBit)
         mode = GPDM_SINK8;
      else if (selHi && selLo && !dataBit)
         mode = GPDM_SINK50;
   end

   always_comb
   begin
      sinkOn       = 1'b0;
      sourceOn     = 1'b0;
      pullupOn     = 1'b0;
      sinkStrength = 2'b00;
      case (mode)
         GPDM_SINK2:   begin sinkOn = 1'b1; sinkStrength = 2'b01; end
         GPDM_SINK8:   begin sinkOn = 1'b1; sinkStrength = 2'b10; end
         GPDM_SINK50:  begin sinkOn = 1'b1; sinkStrength = 2'b11; end
         GPDM_DRIVEHI: sourceOn = 1'b1;
         GPDM_RESIST:  pullupOn = 1'b1;
         default:      sinkStrength = 2'b00;
      endcase
   end

   // ttl only for hi-z with data high; hysteresis lives in the pad
   assign ttlThreshold = dataBit & ~selLo & ~selHi;
endmodule : gpdm_pin_drive

/* File: verilog/gpdm_sync.sv */
// two-stage synchroniser bank for asynchronous pin levels
// assumes a single system clock
`timescale 1ns/1ps
module gpdm_sync
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   typedef struct packed
   {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } gpdm_sync_t;

   gpdm_sync_t state;
   gpdm_sync_t next_state;

   initial
   begin
      if (WIDTH < 1)
         $error("sync width must be positive");
   end

   always_comb
   begin
      next_state.stage1 = asyncIn;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         state <= '0;
      else
         state <= next_state;
   end

   assign syncOut = state.stage2;
endmodule : gpdm_sync

/* File: verilog/gpdm_gpio_ports.sv */
// gpio block: two bidirectional ports with drive modes plus auxiliary inputs
// assumes processor i/o strobes on clk, pins asynchronous to clk
//
// Contract
// - port data reads return synchronised pin levels, not stored data
// - port data writes store outgoing data feeding driver selection
// - each pin's drive depends only on its own data and select bits
// - first port has eight pins; second has two or eight by variant
// - reset clears data and select registers, all pins high impedance
// - both select bits zero turns off every driver of the pin
// - select hi set, lo clear, data zero gives weakest sink
// - select hi clear, lo set, data zero gives medium sink
// - both selects set, data zero gives strongest sink
// - select lo set with data one drives only the active pull-up
// - select hi set, lo clear, data one enables resistive pull-up only
// - ttl threshold only for data one with both selects zero
// - every port bit is individually selectable as interrupt source
// - auxiliary bits 5 and 4 show live d+ and d- levels
// - auxiliary bit 1 shows crystal input level in internal clock mode
// - auxiliary bit 0 shows regulator pin level in ps/2 mode
`timescale 1ns/1ps
module gpdm_gpio_ports
   import gpdm_pkg::*;
#(
   parameter int PORT1_PINS = PORT_WIDTH
)
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [7:0]            ioAddr,
   input  wire logic                  ioWrite,
   input  wire logic                  ioRead,
   input  wire logic [7:0]            ioWdata,
   output logic      [7:0]            ioRdata,
   input  wire logic [PORT_WIDTH-1:0] firstPortPinsIn,
   output logic      [PORT_WIDTH-1:0] firstPortPinsOut,
   output logic      [PORT_WIDTH-1:0] firstPortPinsOe,
   output logic      [PORT_WIDTH-1:0] firstPortPullup,
   output logic      [2*PORT_WIDTH-1:0] firstPortSinkStrength,
   output logic      [PORT_WIDTH-1:0] firstPortTtl,
   input  wire logic [PORT_WIDTH-1:0] secondPortPinsIn,
   output logic      [PORT_WIDTH-1:0] secondPortPinsOut,
   output logic      [PORT_WIDTH-1:0] secondPortPinsOe,
   output logic      [PORT_WIDTH-1:0] secondPortPullup,
   output logic      [2*PORT_WIDTH-1:0] secondPortSinkStrength,
   output logic      [PORT_WIDTH-1:0] secondPortTtl,
   input  wire logic [PORT_WIDTH-1:0] firstPortIrqEnable,
   input  wire logic [PORT_WIDTH-1:0] secondPortIrqEnable,
   output logic      [PORT_WIDTH-1:0] firstPortIrqSource,
   output logic      [PORT_WIDTH-1:0] secondPortIrqSource,
   input  wire logic                  dPlusIn,
   input  wire logic                  dMinusIn,
   input  wire logic                  crystal_in_pin,
   input  wire logic                  regulator_out_pin,
   input  wire logic                  internalClockMode,
   input  wire logic                  ps2Mode
);
   localparam int SYNC_W = 2 * PORT_WIDTH + 4;

   typedef struct packed
   {
      logic [PORT_WIDTH-1:0] port0Data;
      logic [PORT_WIDTH-1:0] port1Data;
      logic [PORT_WIDTH-1:0] port0SelLo;
      logic [PORT_WIDTH-1:0] port0SelHi;
      logic [PORT_WIDTH-1:0] port1SelLo;
      logic [PORT_WIDTH-1:0] port1SelHi;
      logic [7:0]            rdata;
   } gpdm_regs_t;

   gpdm_regs_t            state;
   gpdm_regs_t            next_state;
   logic [SYNC_W-1:0]     syncIn;
   logic [SYNC_W-1:0]     syncLvl;
   logic [PORT_WIDTH-1:0] pin0Live;
   logic [PORT_WIDTH-1:0] pin1Live;
   logic [PORT_WIDTH-1:0] port1Mask;
   logic [7:0]            auxByte;
   logic [PORT_WIDTH-1:0] sink0;
   logic [PORT_WIDTH-1:0] src0;
   logic [PORT_WIDTH-1:0] sink1;
   logic [PORT_WIDTH-1:0] src1;

   initial
   begin
      if (PORT1_PINS != PORT1_NARROW && PORT1_PINS != PORT_WIDTH)
         $error("second port must have two or eight pins");
   end

   // missing pins of the narrow variant are masked everywhere
   assign port1Mask = (PORT1_PINS == PORT_WIDTH) ? 8'hFF : 8'h03;

   assign syncIn = {crystal_in_pin, regulator_out_pin, dPlusIn, dMinusIn,
                    secondPortPinsIn, firstPortPinsIn};

   gpdm_sync #(.WIDTH(SYNC_W)) u_sync
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .asyncIn (syncIn),
      .syncOut (syncLvl)
   );

   assign pin0Live = syncLvl[PORT_WIDTH-1:0];
   assign pin1Live = syncLvl[2*PORT_WIDTH-1:PORT_WIDTH] & port1Mask;

   always_comb
   begin
      auxByte = 8'h00;
      auxByte[AUX_DMINUS_BIT]    = syncLvl[2*PORT_WIDTH];
      auxByte[AUX_DPLUS_BIT]     = syncLvl[2*PORT_WIDTH+1];
      auxByte[AUX_REGULATOR_BIT] = syncLvl[2*PORT_WIDTH+2] & ps2Mode;
      auxByte[AUX_CRYSTAL_BIT]   = syncLvl[2*PORT_WIDTH+3] & internalClockMode;
   end

   always_comb
   begin
      next_state = state;
      if (ioWrite)
      begin
         case (ioAddr)
            OFS_PORT0_DATA:   next_state.port0Data  = ioWdata;
            OFS_PORT1_DATA:   next_state.port1Data  = ioWdata & port1Mask;
            OFS_PORT0_SEL_LO: next_state.port0SelLo = ioWdata;
            OFS_PORT0_SEL_HI: next_state.port0SelHi = ioWdata;
            OFS_PORT1_SEL_LO: next_state.port1SelLo = ioWdata & port1Mask;
            OFS_PORT1_SEL_HI: next_state.port1SelHi = ioWdata & port1Mask;
            default:          next_state.rdata      = state.rdata; // aux port is read-only
         endcase
      end
      if (ioRead)
      begin
         case (ioAddr)
            OFS_PORT0_DATA: next_state.rdata = pin0Live;
            OFS_PORT1_DATA: next_state.rdata = pin1Live;
            OFS_AUX_INPUT:  next_state.rdata = auxByte;
            // select registers are write-only and read back zero
            default:        next_state.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         state <= '0;
      else
         state <= next_state;
   end

   assign ioRdata = state.rdata;

   genvar i;
   generate
      for (i = 0; i < PORT_WIDTH; i++)
      begin : g_pin
         gpdm_pin_drive u_p0
         (
            .dataBit      (state.port0Data[i]),
            .selLo        (state.port0SelLo[i]),
            .selHi        (state.port0SelHi[i]),
            .sinkOn       (sink0[i]),
            .sourceOn     (src0[i]),
            .pullupOn     (firstPortPullup[i]),
            .sinkStrength (firstPortSinkStrength[2*i+1:2*i]),
            .ttlThreshold (firstPortTtl[i])
         );
         gpdm_pin_drive u_p1
         (
            .dataBit      (state.port1Data[i]),
            .selLo        (state.port1SelLo[i]),
            .selHi        (state.port1SelHi[i]),
            .sinkOn       (sink1[i]),
            .sourceOn     (src1[i]),
            .pullupOn     (secondPortPullup[i]),
            .sinkStrength (secondPortSinkStrength[2*i+1:2*i]),
            .ttlThreshold (secondPortTtl[i])
         );
      end
   endgenerate

   // pin drives its data level when sinking or sourcing
   assign firstPortPinsOut  = src0;
   assign firstPortPinsOe   = sink0 | src0;
   assign secondPortPinsOut = src1;
   assign secondPortPinsOe  = sink1 | src1;

   // per-bit interrupt source gating; level stays with the pin
   assign firstPortIrqSource  = pin0Live & firstPortIrqEnable;
   assign secondPortIrqSource = pin1Live & secondPortIrqEnable & port1Mask;

   sequence selZeroSeq;
      state.port0SelLo[0] == 1'b0 && state.port0SelHi[0] == 1'b0;
   endsequence

   hiz_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
      selZeroSeq |-> !firstPortPinsOe[0] && !firstPortPullup[0])
      else $error("pin driven with selects zero");

   data_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      ioWrite && ioAddr == OFS_PORT0_DATA |=> state.port0Data == $past(ioWdata))
      else $error("port data write lost");

   pin_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      ioRead && ioAddr == OFS_PORT0_DATA |=> ioRdata == $past(pin0Live))
      else $error("port read not pin level");

   weak_sink_a: assert property (@(posedge clk) disable iff (!rst_b)
      state.port0SelHi[0] && !state.port0SelLo[0] && !state.port0Data[0]
      |-> firstPortPinsOe[0] && !firstPortPinsOut[0] && firstPortSinkStrength[1:0] == 2'b01)
      else $error("weak sink wrong");

   med_sink_a: assert property (@(posedge clk) disable iff (!rst_b)
      !state.port0SelHi[0] && state.port0SelLo[0] && !state.port0Data[0]
      |-> firstPortPinsOe[0] && firstPortSinkStrength[1:0] == 2'b10)
      else $error("medium sink wrong");

   high_sink_a: assert property (@(posedge clk) disable iff (!rst_b)
      state.port0SelHi[0] && state.port0SelLo[0] && !state.port0Data[0]
      |-> firstPortPinsOe[0] && firstPortSinkStrength[1:0] == 2'b11)
      else $error("strong sink wrong");

   drive_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      state.port0SelLo[0] && state.port0Data[0]
      |-> firstPortPinsOe[0] && firstPortPinsOut[0] && !firstPortPullup[0])
      else $error("drive high wrong");

   resist_pull_a: assert property (@(posedge clk) disable iff (!rst_b)
      state.port0SelHi[0] && !state.port0SelLo[0] && state.port0Data[0]
      |-> firstPortPullup[0] && !firstPortPinsOe[0])
      else $error("resistive pull-up wrong");

   ttl_thresh_a: assert property (@(posedge clk) disable iff (!rst_b)
      firstPortTtl[0] == (state.port0Data[0] && !state.port0SelLo[0] && !state.port0SelHi[0]))
      else $error("threshold select wrong");

   aux_reserved_a: assert property (@(posedge clk) disable iff (!rst_b)
      ioRead && ioAddr == OFS_AUX_INPUT |=> ioRdata[7:6] == 2'b00 && ioRdata[3:2] == 2'b00)
      else $error("aux reserved bits set");

   aux_dlines_a: assert property (@(posedge clk) disable iff (!rst_b)
      ioRead && ioAddr == OFS_AUX_INPUT ##1 1'b1 |-> ioRdata[5:4] == $past(auxByte[5:4]))
      else $error("d line state wrong");
endmodule : gpdm_gpio_ports

/* File: bench/gpdm_pin_board.sv */
// board model on one gpio port: external drivers and floating pins
// assumes the device enables win; the board only drives released pins
`timescale 1ns/1ps
module gpdm_pin_board
(
   input  wire logic       clk,
   input  wire logic [7:0] pinsOut,
   input  wire logic [7:0] pinsOe,
   input  wire logic [7:0] resPullup,
   input  wire logic [7:0] extVal,
   input  wire logic [7:0] extEn,
   output logic      [7:0] pinsIn
);
   // a floating pin toggles so a stale level never reads back by luck
   logic [7:0] floatPat = 8'h5A;

   always @(posedge clk)
      floatPat <= ~floatPat;

   always_comb
      for (int i = 0; i < 8; i++)
         pinsIn[i] = pinsOe[i] ? pinsOut[i] : extEn[i] ? extVal[i] : resPullup[i] ? 1'b1 : floatPat[i];
endmodule : gpdm_pin_board

/* File: bench/gpdm_gpio_ports_bench.sv */
// self-checking bench for the gpio ports block
// assumes a board model per port and two-flop pin synchronisers
`timescale 1ns/1ps
module gpdm_gpio_ports_bench;
   import gpdm_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  ioAddr = 8'h00;
   logic [7:0]  ioWdata = 8'h00;
   logic        ioWrite = 1'b0;
   logic        ioRead = 1'b0;
   logic [7:0]  ioRdata;
   logic [7:0]  pOut[2], pOe[2], pPu[2], pTtl[2], pIn[2], xVal[2], xEn[2], irqEn[2], irqSrc[2];
   logic [15:0] pStr[2];
   logic [7:0]  nOe;
   logic [7:0]  nRdata;
   logic [5:0]  aux = 6'h00;
   logic [31:0] rng = 32'hB7F0;
   logic [7:0]  expQ[$];
   logic        rdSeen = 1'b0;
   int          nErrors = 0;
   int          nTests = 0;

   always #25 clk = ~clk;

   gpdm_gpio_ports dut_u (.clk(clk), .rst_b(rst_b), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
      .ioWdata(ioWdata), .ioRdata(ioRdata), .firstPortPinsIn(pIn[0]), .firstPortPinsOut(pOut[0]),
      .firstPortPinsOe(pOe[0]), .firstPortPullup(pPu[0]), .firstPortSinkStrength(pStr[0]),
      .firstPortTtl(pTtl[0]), .secondPortPinsIn(pIn[1]), .secondPortPinsOut(pOut[1]),
      .secondPortPinsOe(pOe[1]), .secondPortPullup(pPu[1]), .secondPortSinkStrength(pStr[1]),
      .secondPortTtl(pTtl[1]), .firstPortIrqEnable(irqEn[0]), .secondPortIrqEnable(irqEn[1]),
      .firstPortIrqSource(irqSrc[0]), .secondPortIrqSource(irqSrc[1]), .dPlusIn(aux[5]),
      .dMinusIn(aux[4]), .crystal_in_pin(aux[3]), .regulator_out_pin(aux[2]),
      .internalClockMode(aux[1]), .ps2Mode(aux[0]));

   gpdm_pin_board board0_u (.clk(clk), .pinsOut(pOut[0]), .pinsOe(pOe[0]), .resPullup(pPu[0]),
      .extVal(xVal[0]), .extEn(xEn[0]), .pinsIn(pIn[0]));
   gpdm_pin_board board1_u (.clk(clk), .pinsOut(pOut[1]), .pinsOe(pOe[1]), .resPullup(pPu[1]),
      .extVal(xVal[1]), .extEn(xEn[1]), .pinsIn(pIn[1]));

   // narrow variant shares the bus; only its second port enables and read data are watched
   gpdm_gpio_ports #(.PORT1_PINS(PORT1_NARROW)) narrow_u (.clk(clk), .rst_b(rst_b), .ioAddr(ioAddr),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(nRdata), .firstPortPinsIn(pIn[0]),
      .firstPortPinsOut(), .firstPortPinsOe(), .firstPortPullup(), .firstPortSinkStrength(), .firstPortTtl(),
      .secondPortPinsIn(pIn[1]), .secondPortPinsOut(), .secondPortPinsOe(nOe), .secondPortPullup(),
      .secondPortSinkStrength(), .secondPortTtl(), .firstPortIrqEnable(irqEn[0]),
      .secondPortIrqEnable(irqEn[1]), .firstPortIrqSource(), .secondPortIrqSource(), .dPlusIn(aux[5]),
      .dMinusIn(aux[4]), .crystal_in_pin(aux[3]), .regulator_out_pin(aux[2]),
      .internalClockMode(aux[1]), .ps2Mode(aux[0]));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      nTests++;
      if (g !== e)
      begin
         nErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      ioAddr = a;
      ioWdata = d;
      ioWrite = 1'b1;
      @(negedge clk);
      ioWrite = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      ioAddr = a;
      ioRead = 1'b1;
      expQ.push_back(e);
      @(negedge clk);
      ioRead = 1'b0;
   endtask : rd

   // configure one port, check the drive decode, then read the pins back
   task automatic portRun(input int p, input logic [7:0] d, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0]  oe;
      logic [7:0]  pu;
      logic [7:0]  pin;
      logic [15:0] s;
      wr(p ? OFS_PORT1_DATA : OFS_PORT0_DATA, d);
      wr(p ? OFS_PORT1_SEL_LO : OFS_PORT0_SEL_LO, lo);
      wr(p ? OFS_PORT1_SEL_HI : OFS_PORT0_SEL_HI, hi);
      oe = (lo | hi) & ~(d & ~lo);
      pu = d & hi & ~lo;
      for (int i = 0; i < 8; i++)
         s[2*i+:2] = d[i] ? 2'b00 : {lo[i], hi[i]};
      chk("pinsOe", oe, pOe[p]);
      chk("pinsOut", oe & d & lo, pOe[p] & pOut[p]);
      chk("pullup", pu, pPu[p]);
      chk("strengthLo", s[7:0], pStr[p][7:0]);
      chk("strengthHi", s[15:8], pStr[p][15:8]);
      chk("ttl", d & ~lo & ~hi, pTtl[p]);
      if (p)
         chk("narrowOe", oe & 8'h03, nOe);
      xVal[p] = 8'(xs());
      xEn[p] = ~oe & ~pu;
      irqEn[p] = 8'(xs());
      repeat (3) @(negedge clk);
      pin = (oe & d & lo) | (~oe & pu) | (~oe & ~pu & xVal[p]);
      chk("irqSource", pin & irqEn[p], irqSrc[p]);
      rd(p ? OFS_PORT1_DATA : OFS_PORT0_DATA, pin);
      chk("narrowRead", p ? pin & 8'h03 : pin, nRdata);
   endtask : portRun

   task automatic finishTest();
      if (nErrors == 0 && nTests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finishTest

   // read data is compared half a cycle after the read edge
   always @(posedge clk)
      rdSeen <= ioRead;

   always @(negedge clk)
      if (rdSeen)
      begin
         if (expQ.size() == 0)
            chk("readCount", 8'h00, 8'hFF);
         else
            chk("ioRdata", expQ.pop_front(), ioRdata);
      end

   initial
   begin
      repeat (20000) @(posedge clk);
      nErrors++;
      finishTest();
   end

   initial
   begin
      logic [31:0] r;
      xVal = '{8'h00, 8'h00};
      xEn = '{8'hFF, 8'hFF};
      irqEn = '{8'h00, 8'h00};
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      for (int p = 0; p < 2; p++)
      begin
         chk("resetOe", 8'h00, pOe[p]);
         chk("resetPullup", 8'h00, pPu[p]);
      end
      portRun(0, 8'hAA, 8'hCC, 8'hF0);
      portRun(1, 8'hAA, 8'hCC, 8'hF0);
      for (int i = 0; i < 12; i++)
         portRun(i % 2, 8'(xs()), 8'(xs()), 8'(xs()));
      portRun(0, 8'h00, 8'hFF, 8'h00);
      portRun(0, 8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         r = xs();
         aux = {r[3:0], 2'(i)};
         wr(OFS_AUX_INPUT, 8'hFF);
         repeat (3) @(negedge clk);
         rd(OFS_AUX_INPUT, {2'b00, aux[5], aux[4], 2'b00, aux[3] & aux[1], aux[2] & aux[0]});
      end
      rd(OFS_PORT0_SEL_LO, 8'h00);
      rd(8'h05, 8'h00);
      portRun(1, 8'hFF, 8'h0F, 8'h3C);
      @(negedge clk);
      rst_b = 1'b0;
      @(negedge clk);
      for (int p = 0; p < 2; p++)
      begin
         chk("midResetOe", 8'h00, pOe[p]);
         chk("midResetPullup", 8'h00, pPu[p]);
      end
      chk("midResetRdata", 8'h00, ioRdata);
      rst_b = 1'b1;
      for (int i = 0; i < 10 && expQ.size() != 0; i++)
         @(negedge clk);
      if (expQ.size() != 0)
         nErrors++;
      finishTest();
   end
endmodule : gpdm_gpio_ports_bench
